// ==== wsl_pkg.sv ====
// wake-up start logic: register map, field layout and reset values
// assumes a 32-bit avalon-mm byte-addressed system-configuration bus
package wsl_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_LINES = 13;
    localparam int BYTE_W = 8;
    localparam int NUM_BYTES = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] POL_ADDR = 32'h4004_8200;
    localparam logic [31:0] EN_ADDR = 32'h4004_8204;
    localparam logic [31:0] CLR_ADDR = 32'h4004_8208;
    localparam logic [31:0] STAT_ADDR = 32'h4004_820C;
    localparam logic [31:0] IRQEN_ADDR = 32'h4004_8210;

    ////////////////////////////////////////////////////////////////////////////
    // bit positions of the start logic inputs
    localparam int BIT_P0_PIN0 = 0;
    localparam int BIT_P0_PIN8 = 8;
    localparam int BIT_P0_PIN9 = 9;
    localparam int BIT_P0_PIN10 = 10;
    localparam int BIT_P0_PIN11 = 11;
    localparam int BIT_P1_PIN0 = 12;
    localparam logic [12:0] VALID_MASK = 13'h1_F01;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [12:0] POL_RST = 13'h0_000;
    localparam logic [12:0] EN_RST = 13'h0_000;
    localparam logic [12:0] PEND_RST = 13'h0_000;
    localparam logic [12:0] IRQEN_RST = 13'h0_000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // cycles from request to the waitrequest-low answer
    localparam int BUS_WAIT_CYCLES = 1;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } wsl_bus_state_t;

endpackage

// ==== wsl_pin_edge.sv ====
// wake-up start logic: one pin, synchroniser and selectable edge detector
// assumes pinIn is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none

module wsl_pin_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    input wire logic polarity,
    output logic edgeHit
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic [2:0] fill;
    } wsl_edge_st_t;

    wsl_edge_st_t st_r;
    wsl_edge_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = pinIn;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
        st_nxt.fill = {st_r.fill[1:0], 1'b1};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // 0 picks the falling transition, 1 the rising one; quiet until samples hold real pin levels
    assign edgeHit = st_r.fill[2]
        & (polarity ? (st_r.sync & ~st_r.prev) : (~st_r.sync & st_r.prev));

    a_fall_only: assert property (@(posedge clk) disable iff (rst)
        (!polarity && st_r.sync && !st_r.prev) |-> !edgeHit)
        else $error("rising transition flagged while falling edge selected");

endmodule // wsl_pin_edge

`default_nettype wire

// ==== wsl_bus_slave.sv ====
// wake-up start logic: avalon-mm handshake with one wait cycle
// assumes the master holds its request until it sees waitrequest low
`timescale 1ns/1ns
`default_nettype none

module wsl_bus_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic capture,
    output logic commit
);

    typedef struct packed {
        wsl_pkg::wsl_bus_state_t state;
        logic waitReq;
    } wsl_bus_st_t;

    wsl_bus_st_t st_r;
    wsl_bus_st_t st_nxt;
    logic req;

    assign req = read | write;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            wsl_pkg::BUS_IDLE: begin
                if (req) begin
                    st_nxt.state = wsl_pkg::BUS_ACK;
                    st_nxt.waitReq = 1'b0;
                end
            end
            wsl_pkg::BUS_ACK: begin
                st_nxt.state = wsl_pkg::BUS_IDLE;
                st_nxt.waitReq = 1'b1;
            end
            default: begin
                st_nxt.state = wsl_pkg::BUS_IDLE;
                st_nxt.waitReq = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{state: wsl_pkg::BUS_IDLE, waitReq: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign waitrequest = st_r.waitReq;
    assign capture = (st_r.state == wsl_pkg::BUS_IDLE) && req;
    assign commit = (st_r.state == wsl_pkg::BUS_ACK) && req;

    a_wait_one: assert property (@(posedge clk) disable iff (rst)
        (req && waitrequest) |=> !waitrequest)
        else $error("request not answered after one wait cycle");

endmodule // wsl_bus_slave

`default_nettype wire

// ==== wsl_wakeup_start.sv ====
// wake-up start logic: six wake pins, edge select, enable, pending, clear
// assumes an avalon-mm master on clk and asynchronous wake pins
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module wsl_wakeup_start (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic port0Pin0,
    input wire logic port0Pin8,
    input wire logic port0Pin9,
    input wire logic port0Pin10,
    input wire logic port0Pin11,
    input wire logic port1Pin0,
    output logic [12:0] wakeIrq,
    output logic irq
);

    typedef struct packed {
        logic [12:0] pol;
        logic [12:0] en;
        logic [12:0] pending;
        logic [12:0] irqEn;
        logic [31:0] rdata;
        logic irqOut;
    } wsl_top_st_t;

    wsl_top_st_t st_r;
    wsl_top_st_t st_nxt;

    logic capture;
    logic commit;
    logic [12:0] pinVec;
    logic [12:0] edgeVec;
    logic [12:0] armEvt;
    logic [12:0] clrBits;
    logic [31:0] wmask;
    logic [12:0] lineMask;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake

    wsl_bus_slave uBus (
        .clk(clk),
        .rst(rst),
        .read(read),
        .write(write),
        .waitrequest(waitrequest),
        .capture(capture),
        .commit(commit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin edge detection, one detector per populated bit

    assign pinVec = {port1Pin0, port0Pin11, port0Pin10, port0Pin9, port0Pin8,
                     7'h00, port0Pin0};

    for (genvar i = 0; i < wsl_pkg::NUM_LINES; i++) begin : gLine
        if (wsl_pkg::VALID_MASK[i]) begin : gPin
            wsl_pin_edge uEdge (
                .clk(clk),
                .rst(rst),
                .pinIn(pinVec[i]),
                .polarity(st_r.pol[i]),
                .edgeHit(edgeVec[i])
            );
        end else begin : gNone
            assign edgeVec[i] = 1'b0;
        end
    end

    // only enabled inputs may register a start event
    assign armEvt = edgeVec & st_r.en;

    ////////////////////////////////////////////////////////////////////////////
    // register file and start state

    always_comb begin
        st_nxt = st_r;
        clrBits = 13'h0_000;
        wmask = {{wsl_pkg::BYTE_W{byteenable[3]}}, {wsl_pkg::BYTE_W{byteenable[2]}},
                 {wsl_pkg::BYTE_W{byteenable[1]}}, {wsl_pkg::BYTE_W{byteenable[0]}}};
        lineMask = wmask[12:0] & wsl_pkg::VALID_MASK;
        if (commit && write) begin
            case (address)
                wsl_pkg::POL_ADDR: begin
                    // unused positions keep zero
                    st_nxt.pol = (st_r.pol & ~lineMask)
                        | (writedata[12:0] & lineMask);
                end
                wsl_pkg::EN_ADDR: begin
                    st_nxt.en = (st_r.en & ~lineMask) | (writedata[12:0] & lineMask);
                end
                wsl_pkg::IRQEN_ADDR: begin
                    st_nxt.irqEn = (st_r.irqEn & ~lineMask)
                        | (writedata[12:0] & lineMask);
                end
                wsl_pkg::CLR_ADDR: begin
                    clrBits = writedata[12:0] & lineMask;
                end
                default: begin
                end
            endcase
        end
        // a start event in the clearing cycle survives the clear
        st_nxt.pending = ((st_r.pending & ~clrBits) | armEvt)
            & wsl_pkg::VALID_MASK;
        if (capture && read) begin
            case (address)
                wsl_pkg::POL_ADDR: st_nxt.rdata = {19'h0_0000, st_r.pol};
                wsl_pkg::EN_ADDR: st_nxt.rdata = {19'h0_0000, st_r.en};
                wsl_pkg::STAT_ADDR: st_nxt.rdata = {19'h0_0000, st_r.pending};
                wsl_pkg::IRQEN_ADDR: st_nxt.rdata = {19'h0_0000, st_r.irqEn};
                default: st_nxt.rdata = wsl_pkg::READ_ZERO;
            endcase
        end
        st_nxt.irqOut = |(st_nxt.pending & st_nxt.irqEn);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{pol: wsl_pkg::POL_RST,
                      en: wsl_pkg::EN_RST,
                      pending: wsl_pkg::PEND_RST,
                      irqEn: wsl_pkg::IRQEN_RST,
                      rdata: wsl_pkg::RDATA_RST,
                      irqOut: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign readdata = st_r.rdata;
    // line n carries the pending start state of bit n
    assign wakeIrq = st_r.pending;
    assign irq = st_r.irqOut;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_pol_unused: assert property (@(posedge clk) disable iff (rst)
        (st_r.pol & ~wsl_pkg::VALID_MASK) == 13'h0_000)
        else $error("unused polarity bit became set");

    a_pol_write: assert property (@(posedge clk) disable iff (rst)
        (commit && write && address == wsl_pkg::POL_ADDR && byteenable == 4'hF)
        |=> st_r.pol == ($past(writedata[12:0]) & wsl_pkg::VALID_MASK))
        else $error("polarity register did not take the written value");

    a_line_map: assert property (@(posedge clk) disable iff (rst)
        (wakeIrq & ~wsl_pkg::VALID_MASK) == 13'h0_000)
        else $error("wake line raised at a position with no input");

    a_edge_sets: assert property (@(posedge clk) disable iff (rst)
        (armEvt != 13'h0_000) |=> ((wakeIrq & $past(armEvt)) == $past(armEvt)))
        else $error("enabled edge did not raise its wake line");

    a_no_spurious: assert property (@(posedge clk) disable iff (rst)
        ((st_r.pending & ~$past(st_r.pending)) & ~$past(armEvt)) == 13'h0_000)
        else $error("pending bit set without an enabled edge");

    a_clear_bit: assert property (@(posedge clk) disable iff (rst)
        (clrBits != 13'h0_000 && (clrBits & armEvt) == 13'h0_000)
        |=> (st_r.pending & $past(clrBits)) == 13'h0_000)
        else $error("cleared start state still pending");

    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        ((clrBits & armEvt) != 13'h0_000)
        |=> (st_r.pending & $past(clrBits & armEvt)) == $past(clrBits & armEvt))
        else $error("start event lost to a simultaneous clear");

    a_status_read: assert property (@(posedge clk) disable iff (rst)
        (capture && read && address == wsl_pkg::STAT_ADDR)
        ##1 !waitrequest |-> readdata == {19'h0_0000, $past(st_r.pending)})
        else $error("status read does not show pending state");

    a_rise_pick: assert property (@(posedge clk) disable iff (rst)
        (edgeVec & st_r.pol & ~($past(pinVec, 2) & ~$past(pinVec, 3))) == 13'h0_000)
        else $error("rising input flagged without a rising pin");

    a_fall_pick: assert property (@(posedge clk) disable iff (rst)
        (edgeVec & ~st_r.pol & ~(~$past(pinVec, 2) & $past(pinVec, 3))) == 13'h0_000)
        else $error("falling input flagged without a falling pin");

    a_edge_seen: assert property (@(posedge clk) disable iff (rst)
        !$past(rst, 4) |-> (~edgeVec & wsl_pkg::VALID_MASK & ~(st_r.pol ^ $past(pinVec, 2))
        & (st_r.pol ^ $past(pinVec, 3))) == 13'h0_000)
        else $error("selected pin transition produced no edge");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(wakeIrq & st_r.irqEn))
        else $error("interrupt output disagrees with enabled pending bits");

    a_read_answer: assert property (@(posedge clk) disable iff (rst)
        (capture && read) |=> !waitrequest ##1 waitrequest)
        else $error("read answer not exactly one cycle wide");

    ////////////////////////////////////////////////////////////////////////////
    // register file checks

    a_en_write: assert property (@(posedge clk) disable iff (rst)
        (commit && write && address == wsl_pkg::EN_ADDR && byteenable == 4'hF)
        |=> st_r.en == ($past(writedata[12:0]) & wsl_pkg::VALID_MASK))
        else $error("enable register did not take the written value");

    a_irqen_write: assert property (@(posedge clk) disable iff (rst)
        (commit && write && address == wsl_pkg::IRQEN_ADDR && byteenable == 4'hF)
        |=> st_r.irqEn == ($past(writedata[12:0]) & wsl_pkg::VALID_MASK))
        else $error("interrupt enable register did not take the written value");

    a_pol_keep: assert property (@(posedge clk) disable iff (rst)
        !(commit && write && address == wsl_pkg::POL_ADDR) |=> $stable(st_r.pol))
        else $error("polarity changed without a polarity write");

    a_en_keep: assert property (@(posedge clk) disable iff (rst)
        !(commit && write && address == wsl_pkg::EN_ADDR) |=> $stable(st_r.en))
        else $error("enable changed without an enable write");

    a_irqen_keep: assert property (@(posedge clk) disable iff (rst)
        !(commit && write && address == wsl_pkg::IRQEN_ADDR) |=> $stable(st_r.irqEn))
        else $error("interrupt enable changed without its write");

    a_stat_nowrite: assert property (@(posedge clk) disable iff (rst)
        (commit && write && address == wsl_pkg::STAT_ADDR)
        |=> $stable(st_r.pol) && $stable(st_r.en) && $stable(st_r.irqEn))
        else $error("status write altered a register");

    a_clr_source: assert property (@(posedge clk) disable iff (rst)
        (clrBits != 13'h0_000) |-> (commit && write && address == wsl_pkg::CLR_ADDR))
        else $error("start state cleared without a clear write");

    ////////////////////////////////////////////////////////////////////////////
    // start state checks

    a_pend_hold: assert property (@(posedge clk) disable iff (rst)
        ($past(st_r.pending) & ~st_r.pending & ~$past(clrBits)) == 13'h0_000)
        else $error("pending bit dropped without a clear");

    a_off_ignored: assert property (@(posedge clk) disable iff (rst)
        ((edgeVec & ~st_r.en & ~st_r.pending) != 13'h0_000)
        |=> (wakeIrq & $past(edgeVec & ~st_r.en & ~st_r.pending)) == 13'h0_000)
        else $error("edge on a disabled input raised its wake line");

    ////////////////////////////////////////////////////////////////////////////
    // read path and bus handshake checks

    a_read_pol: assert property (@(posedge clk) disable iff (rst)
        (capture && read && address == wsl_pkg::POL_ADDR)
        |=> readdata == {19'h0_0000, $past(st_r.pol)})
        else $error("polarity read returned the wrong value");

    a_read_en: assert property (@(posedge clk) disable iff (rst)
        (capture && read && address == wsl_pkg::EN_ADDR)
        |=> readdata == {19'h0_0000, $past(st_r.en)})
        else $error("enable read returned the wrong value");

    a_read_irqen: assert property (@(posedge clk) disable iff (rst)
        (capture && read && address == wsl_pkg::IRQEN_ADDR)
        |=> readdata == {19'h0_0000, $past(st_r.irqEn)})
        else $error("interrupt enable read returned the wrong value");

    a_read_zero: assert property (@(posedge clk) disable iff (rst)
        (capture && read && address != wsl_pkg::POL_ADDR && address != wsl_pkg::EN_ADDR
        && address != wsl_pkg::STAT_ADDR && address != wsl_pkg::IRQEN_ADDR)
        |=> readdata == wsl_pkg::READ_ZERO)
        else $error("unmapped or write-only register read as nonzero");

    a_rdata_upper: assert property (@(posedge clk) disable iff (rst)
        readdata[31:13] == 19'h0_0000)
        else $error("read data above the used bits is nonzero");

    a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        !(capture && read) |=> $stable(readdata))
        else $error("read data changed without a read");

    a_wait_idle: assert property (@(posedge clk) disable iff (rst)
        (waitrequest && !read && !write) |=> waitrequest)
        else $error("waitrequest dropped with no request");

    a_wr_once: assert property (@(posedge clk) disable iff (rst)
        commit |=> !commit)
        else $error("one access committed twice");

endmodule // wsl_wakeup_start

`default_nettype wire

// ==== wsl_wake_partner.sv ====
// wake-up start logic bench: wake pins and processor interrupt controller
// assumes the bench sets target pin levels; pins change only after a clock edge
`timescale 1ns/1ns
`default_nettype none

module wsl_wake_partner (
    input wire logic clk,
    input wire logic [5:0] levelCmd,
    input wire logic [12:0] lineEnable,
    input wire logic [12:0] wakeIrq,
    output logic [5:0] pinOut,
    output logic wakeUp
);
    // pins hold each level until the next command, many cycles at a time
    always @(posedge clk) begin
        pinOut <= levelCmd;
    end

    // controller wakes only on lines that software enabled
    assign wakeUp = |(wakeIrq & lineEnable);
endmodule // wsl_wake_partner

`default_nettype wire

// ==== tb_top.sv ====
// wake-up start logic bench: avalon master, pin stimulus, read-data scoreboard
// assumes one clock at 100 MHz and the one-wait-cycle bus answer
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic clk, rst, read, write, waitrequest, irq, wakeUp, p;
    logic [31:0] address, writedata, readdata, m;
    logic [3:0] byteenable;
    logic [5:0] levelCmd, pins;
    logic [12:0] wakeIrq, lineEnable;
    logic [31:0] expQ[$];
    int errTotal, samplesChecked;

    wsl_wakeup_start u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .port0Pin0(pins[0]),
        .port0Pin8(pins[1]), .port0Pin9(pins[2]), .port0Pin10(pins[3]),
        .port0Pin11(pins[4]), .port1Pin0(pins[5]), .wakeIrq(wakeIrq), .irq(irq));

    wsl_wake_partner u_partner (.clk(clk), .levelCmd(levelCmd), .lineEnable(lineEnable),
        .wakeIrq(wakeIrq), .pinOut(pins), .wakeUp(wakeUp));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finalReport();
        $display("checks %0d errors %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one access; holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            errTotal++;
            $display("mismatch at %0t: bus timeout", $time);
            finalReport();
        end else begin
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task automatic bus_rd(input logic [31:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // scoreboard: read data is taken at the edge that sees waitrequest low
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check(readdata, expQ.pop_front());
        end
    end

    function automatic int bit_of(input int i);
        return (i == 0) ? 0 : i + 7;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] regs [6];
        void'($urandom(32'hd2ca));
        regs = '{wsl_pkg::POL_ADDR, wsl_pkg::EN_ADDR, wsl_pkg::STAT_ADDR,
            wsl_pkg::IRQEN_ADDR, wsl_pkg::CLR_ADDR, 32'h4004_8300};
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 32'h0000_0000;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        levelCmd = 6'h3F;
        lineEnable = 13'h1_F01;
        errTotal = 0;
        samplesChecked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, wsl_pkg::STAT_ADDR, 32'hFFFF_FFFF);
        for (int k = 0; k < 6; k++) begin
            bus_rd(regs[k], 32'h0000_0000);
        end
        bus(1'b1, wsl_pkg::POL_ADDR, 32'hFFFF_FFFF);
        bus_rd(wsl_pkg::POL_ADDR, 32'h0000_1F01);
        for (int i = 0; i < 6; i++) begin
            p = 1'($urandom);
            m = 32'h0000_0001 << bit_of(i);
            levelCmd[i] <= p;
            repeat (6) @(posedge clk);
            bus(1'b1, wsl_pkg::POL_ADDR, p ? m : 32'h0000_0000);
            bus(1'b1, wsl_pkg::EN_ADDR, m);
            bus(1'b1, wsl_pkg::IRQEN_ADDR, (i % 2 == 0) ? m : 32'h0000_0000);
            bus(1'b1, wsl_pkg::CLR_ADDR, 32'hFFFF_FFFF);
            levelCmd[i] <= !p;
            repeat (6) @(posedge clk);
            bus_rd(wsl_pkg::STAT_ADDR, 32'h0000_0000);
            levelCmd[i] <= p;
            repeat (6) @(posedge clk);
            bus_rd(wsl_pkg::STAT_ADDR, m);
            check(32'(wakeIrq), m);
            check(32'(irq), (i % 2 == 0) ? 32'h0000_0001 : 32'h0000_0000);
            check(32'(wakeUp), 32'h0000_0001);
            bus(1'b1, wsl_pkg::CLR_ADDR, m);
            bus_rd(wsl_pkg::STAT_ADDR, 32'h0000_0000);
            check(32'(irq), 32'h0000_0000);
            check(32'(wakeUp), 32'h0000_0000);
        end
        bus(1'b1, wsl_pkg::EN_ADDR, 32'h0000_0000);
        bus(1'b1, wsl_pkg::POL_ADDR, 32'h0000_1F01);
        levelCmd <= 6'h00;
        repeat (6) @(posedge clk);
        levelCmd <= 6'h3F;
        repeat (6) @(posedge clk);
        bus_rd(wsl_pkg::STAT_ADDR, 32'h0000_0000);
        check(32'(wakeIrq), 32'h0000_0000);
        repeat (4) @(posedge clk);
        finalReport();
    end
endmodule // tb_top

`default_nettype wire
